//--- common/lsc_pkg.sv
package lsc_pkg;

	// Clock rate and the derived timing counts.
	localparam int CLK_KHZ      = 125000;
	localparam int CLK_MHZ      = 125;
	localparam int CP_FREQ_KHZ  = 250;
	localparam int CP_HALF_CYC  = CLK_KHZ / (2 * CP_FREQ_KHZ);
	localparam int FADE_US1     = 250;
	localparam int FADE_US2     = 500;
	localparam int FADE_US3     = 1000;
	localparam int MODE_DOWN_US = 20;
	localparam int MODE_DOWN_CYC = MODE_DOWN_US * CLK_MHZ;

	// Register offsets on the internal write port.
	localparam logic [4:0] REG_SINK_EN    = 5'h00;
	localparam logic [4:0] REG_MAIN_LEVEL = 5'h01;
	localparam logic [4:0] REG_BANK2_LEVEL = 5'h02;
	localparam logic [4:0] REG_BANK3_LEVEL = 5'h03;
	localparam logic [4:0] REG_FADE_RATE  = 5'h04;
	localparam logic [4:0] REG_BANK2_SEL  = 5'h05;
	localparam logic [4:0] REG_BANK3_SEL  = 5'h06;

	// Values after reset or shutdown.
	localparam logic [4:0] RST_SINK_EN = 5'h00;
	localparam logic [4:0] RST_LEVEL   = 5'h00;
	localparam logic [1:0] RST_FADE    = 2'h0;
	localparam logic [4:0] RST_SEL     = 5'h00;

	// Current code layout, in half-milliamp units.
	localparam logic [4:0] CODE_HALF_BASE = 5'h03;
	localparam logic [4:0] CODE_ONE_BASE  = 5'h0E;
	localparam logic [4:0] CODE_TWO_BASE  = 5'h1E;
	localparam logic [5:0] HALF_AT_ONE    = 6'h0C;
	localparam logic [5:0] HALF_AT_TWO    = 6'h2E;
	localparam logic [5:0] LOW_BIAS_HALF  = 6'h08;

	// Feedback thresholds for the pump mode choice.
	localparam logic [7:0] FB_LOW_THR  = 8'h20;
	localparam logic [7:0] FB_HIGH_THR = 8'h60;
	localparam logic [7:0] FB_IDLE     = 8'hFF;

	typedef enum logic [1:0] {
		CP_1X  = 2'b00,
		CP_1P5 = 2'b01,
		CP_2X  = 2'b10
	} lsc_cp_mode_t;

endpackage : lsc_pkg

//--- design/lsc_fade_engine.sv
`timescale 1ns/1ps
module lsc_fade_engine #(
	parameter int FADE_CYC1 = lsc_pkg::FADE_US1 * lsc_pkg::CLK_MHZ,
	parameter int FADE_CYC2 = lsc_pkg::FADE_US2 * lsc_pkg::CLK_MHZ,
	parameter int FADE_CYC3 = lsc_pkg::FADE_US3 * lsc_pkg::CLK_MHZ
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clear,
	input  wire logic [4:0] target,
	input  wire logic       targetWr,
	input  wire logic [1:0] fadeRate,
	output logic [4:0]      level_q,
	output logic            busy_q
);

	logic [4:0]  level_d;
	logic        busy_d;
	logic [16:0] tick_q;
	logic [16:0] tick_d;
	logic [16:0] period;

	// Selects the step period from the live rate value.
	always_comb begin
		case (fadeRate)
			2'h1:    period = 17'(FADE_CYC1);
			2'h2:    period = 17'(FADE_CYC2);
			default: period = 17'(FADE_CYC3);
		endcase
	end

	// Steps the level toward the target one code per tick.
	always_comb begin
		level_d = level_q;
		tick_d  = tick_q + 17'h1;
		if (clear) begin
			level_d = lsc_pkg::RST_LEVEL;
			tick_d  = 17'h0;
		// (RULE_16) Fade off jumps.
		// (RULE_17) applied immediately.
		end else if (fadeRate == lsc_pkg::RST_FADE) begin
			level_d = target;
			tick_d  = 17'h0;
		// (RULE_13) Ramp starts at once.
		end else if (targetWr) begin
			tick_d = 17'h0;
		// (RULE_14) Live rate period.
		end else if (tick_q + 17'h1 >= period) begin
			tick_d = 17'h0;
			// (RULE_15) Steps toward present target.
			// (RULE_24) One code per tick.
			if (level_q < target) begin
				level_d = level_q + 5'h1;
			end else if (level_q > target) begin
				level_d = level_q - 5'h1;
			end
		end
		busy_d = (level_d != target) && !clear;
	end

	// Registers the fade state.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_q <= lsc_pkg::RST_LEVEL;
			tick_q  <= 17'h0;
			busy_q  <= 1'b0;
		end else begin
			level_q <= level_d;
			tick_q  <= tick_d;
			busy_q  <= busy_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	fade_off_jump_a: assert property ( // RULE_16
		!clear && fadeRate == 2'h0 |=> level_q == $past(target))
		else $error("Level did not jump with fade off.");
	fade_single_step_a: assert property ( // RULE_24
		!$past(clear) && fadeRate != 2'h0 && $past(fadeRate) != 2'h0 && $changed(level_q)
		|-> (level_q == $past(level_q) + 5'h1) || (level_q == $past(level_q) - 5'h1))
		else $error("Ramp moved by more than one code.");
	fade_cover_c: cover property (busy_q ##1 !busy_q && fadeRate != 2'h0);

endmodule : lsc_fade_engine

//--- design/lsc_led_ctrl.sv
// Overview of operation
// (RULE_01) Pump clocks at 250kHz, idle in 1x.
// (RULE_02) Pump multiplier chosen automatically with hysteresis.
// (RULE_03) Lowest sink reading drives pump feedback.
// (RULE_04) Half-milliamp steps from zero to 5mA.
// (RULE_05) One-milliamp steps from 5 to 21mA.
// (RULE_06) Two-milliamp steps from 21 to 25mA.
// (RULE_07) Sink off when disabled or zero code.
// (RULE_08) All sinks start off after power-up.
// (RULE_09) Host writes zero for unused sink enables.
// (RULE_10) Reduced bias at or below 4mA.
// (RULE_11) Five sinks grouped into three banks.
// (RULE_12) Only main bank fades; others immediate.
// (RULE_13) New main level starts ramp at once.
// (RULE_14) Rate change applies to running ramp.
// (RULE_15) New level redirects ramp from present.
// (RULE_16) Disabling fade jumps to final target.
// (RULE_17) Fade disabled applies level immediately.
// (RULE_18) Main code zero means zero milliamps.
// (RULE_19) Host follows ordered fade-in write sequence.
// (RULE_20) Fade value zero disables, one-three rates.
// (RULE_21) Shutdown returns every register to default.
// (RULE_22) All sinks disabled stops clock and pump.
// (RULE_23) Open enabled sink is disabled automatically.
// (RULE_24) Ramp moves one code per tick.
`timescale 1ns/1ps
module lsc_led_ctrl #(
	parameter int FADE_CYC1     = lsc_pkg::FADE_US1 * lsc_pkg::CLK_MHZ,
	parameter int FADE_CYC2     = lsc_pkg::FADE_US2 * lsc_pkg::CLK_MHZ,
	parameter int FADE_CYC3     = lsc_pkg::FADE_US3 * lsc_pkg::CLK_MHZ,
	parameter int MODE_DOWN_CYC = lsc_pkg::MODE_DOWN_CYC
) (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            shutdown,
	input  wire logic            regWrEn,
	input  wire logic [4:0]      regAddr,
	input  wire logic [7:0]      regData,
	input  wire logic [4:0]      sinkOpen,
	input  wire logic [4:0][7:0] sinkVolt,
	output logic [4:0][5:0]      sinkCurrent_q,
	output logic [4:0]           sinkOn_q,
	output logic [1:0]           cpMode_q,
	output logic                 cpClk_q,
	output logic [7:0]           fbLevel_q,
	output logic                 lowBias_q,
	output logic                 sleepMode_q,
	output logic                 fadeBusy_q
);

	// Converts a current code into half-milliamp units.
	function automatic logic [5:0] code_to_half(input logic [4:0] code);
		logic [5:0] half;
		half = 6'h00;
		// (RULE_18) Zero code is off.
		if (code == 5'h00) begin
			half = 6'h00;
		// (RULE_06) Two-milliamp steps.
		end else if (code >= lsc_pkg::CODE_TWO_BASE) begin
			half = lsc_pkg::HALF_AT_TWO + 6'({code - lsc_pkg::CODE_TWO_BASE, 2'b00});
		// (RULE_05) One-milliamp steps.
		end else if (code >= lsc_pkg::CODE_ONE_BASE) begin
			half = lsc_pkg::HALF_AT_ONE + {code - lsc_pkg::CODE_ONE_BASE, 1'b0};
		// (RULE_04) Half-milliamp steps.
		end else if (code > lsc_pkg::CODE_HALF_BASE) begin
			half = {1'b0, code - lsc_pkg::CODE_HALF_BASE};
		end else begin
			half = 6'h01;
		end
		return half;
	endfunction : code_to_half

	logic [4:0]      sinkEn_q;
	logic [4:0]      sinkEn_d;
	logic [4:0]      mainLevel_q;
	logic [4:0]      mainLevel_d;
	logic [4:0]      bank2Level_q;
	logic [4:0]      bank2Level_d;
	logic [4:0]      bank3Level_q;
	logic [4:0]      bank3Level_d;
	logic [1:0]      fadeRate_q;
	logic [1:0]      fadeRate_d;
	logic [4:0]      bank2Sel_q;
	logic [4:0]      bank2Sel_d;
	logic [4:0]      bank3Sel_q;
	logic [4:0]      bank3Sel_d;
	logic            mainWr;
	logic [4:0]      fadeLevel;
	logic            fadeBusy;
	logic [4:0]      openMeta_q;
	logic [4:0]      openSync_q;
	logic [4:0][7:0] voltMeta_q;
	logic [4:0][7:0] voltSync_q;
	logic [4:0][5:0] sinkCurrent_d;
	logic [4:0]      sinkOn_d;
	logic [4:0][4:0] sinkCode;
	logic [7:0]      fbLevel_d;
	logic            lowBias_d;
	logic            sleepMode_d;
	lsc_pkg::lsc_cp_mode_t mode_q;
	lsc_pkg::lsc_cp_mode_t mode_d;
	logic [15:0]     downCnt_q;
	logic [15:0]     downCnt_d;
	logic [8:0]      cpCnt_q;
	logic [8:0]      cpCnt_d;
	logic            cpClk_d;

	assign mainWr = regWrEn && !shutdown && regAddr == lsc_pkg::REG_MAIN_LEVEL;

	// Takes register writes and auto-disables open sinks.
	always_comb begin
		sinkEn_d     = sinkEn_q;
		mainLevel_d  = mainLevel_q;
		bank2Level_d = bank2Level_q;
		bank3Level_d = bank3Level_q;
		fadeRate_d   = fadeRate_q;
		bank2Sel_d   = bank2Sel_q;
		bank3Sel_d   = bank3Sel_q;
		if (regWrEn) begin
			case (regAddr)
				lsc_pkg::REG_SINK_EN:     sinkEn_d     = regData[4:0];
				lsc_pkg::REG_MAIN_LEVEL:  mainLevel_d  = regData[4:0];
				lsc_pkg::REG_BANK2_LEVEL: bank2Level_d = regData[4:0];
				lsc_pkg::REG_BANK3_LEVEL: bank3Level_d = regData[4:0];
				// (RULE_20) Fade rate field.
				lsc_pkg::REG_FADE_RATE:   fadeRate_d   = regData[1:0];
				lsc_pkg::REG_BANK2_SEL:   bank2Sel_d   = regData[4:0];
				lsc_pkg::REG_BANK3_SEL:   bank3Sel_d   = regData[4:0];
				default:                  sinkEn_d     = sinkEn_q;
			endcase
		end
		// (RULE_23) Open sink disabled.
		sinkEn_d = sinkEn_d & ~(openSync_q & sinkEn_q);
		// (RULE_21) Shutdown restores defaults.
		if (shutdown) begin
			sinkEn_d     = lsc_pkg::RST_SINK_EN;
			mainLevel_d  = lsc_pkg::RST_LEVEL;
			bank2Level_d = lsc_pkg::RST_LEVEL;
			bank3Level_d = lsc_pkg::RST_LEVEL;
			fadeRate_d   = lsc_pkg::RST_FADE;
			bank2Sel_d   = lsc_pkg::RST_SEL;
			bank3Sel_d   = lsc_pkg::RST_SEL;
		end
	end

	// Registers the control state; every sink starts disabled.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// (RULE_08) Sinks start off.
			sinkEn_q     <= lsc_pkg::RST_SINK_EN;
			mainLevel_q  <= lsc_pkg::RST_LEVEL;
			bank2Level_q <= lsc_pkg::RST_LEVEL;
			bank3Level_q <= lsc_pkg::RST_LEVEL;
			fadeRate_q   <= lsc_pkg::RST_FADE;
			bank2Sel_q   <= lsc_pkg::RST_SEL;
			bank3Sel_q   <= lsc_pkg::RST_SEL;
		end else begin
			sinkEn_q     <= sinkEn_d;
			mainLevel_q  <= mainLevel_d;
			bank2Level_q <= bank2Level_d;
			bank3Level_q <= bank3Level_d;
			fadeRate_q   <= fadeRate_d;
			bank2Sel_q   <= bank2Sel_d;
			bank3Sel_q   <= bank3Sel_d;
		end
	end

	// Two-stage synchronisers for the analog sense inputs.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			openMeta_q <= 5'h00;
			openSync_q <= 5'h00;
			voltMeta_q <= '0;
			voltSync_q <= '0;
		end else begin
			openMeta_q <= sinkOpen;
			openSync_q <= openMeta_q;
			voltMeta_q <= sinkVolt;
			voltSync_q <= voltMeta_q;
		end
	end

	// Ramps the main bank level; the others bypass it.
	lsc_fade_engine #(
		.FADE_CYC1 (FADE_CYC1),
		.FADE_CYC2 (FADE_CYC2),
		.FADE_CYC3 (FADE_CYC3)
	) u_fade (
		.clk      (clk),
		.rst_n    (rst_n),
		.clear    (shutdown),
		.target   (mainLevel_q),
		.targetWr (mainWr),
		.fadeRate (fadeRate_q),
		.level_q  (fadeLevel),
		.busy_q   (fadeBusy)
	);
	assign fadeBusy_q = fadeBusy;

	// (RULE_11) Bank routing per sink.
	// (RULE_12) Side banks bypass fade.
	generate
		for (genvar i = 0; i < 5; i++) begin : g_sink
			assign sinkCode[i] = bank3Sel_q[i] ? bank3Level_q :
				(bank2Sel_q[i] ? bank2Level_q : fadeLevel);
		end
	endgenerate

	// Computes sink drive, feedback minimum, bias and sleep state.
	always_comb begin
		fbLevel_d = lsc_pkg::FB_IDLE;
		lowBias_d = 1'b1;
		for (int i = 0; i < 5; i++) begin
			// (RULE_07) Off when disabled or zero.
			sinkOn_d[i]      = sinkEn_q[i] && sinkCode[i] != 5'h00;
			sinkCurrent_d[i] = sinkOn_d[i] ? code_to_half(sinkCode[i]) : 6'h00;
			// (RULE_03) Lowest sink feedback.
			if (sinkOn_d[i] && voltSync_q[i] < fbLevel_d) begin
				fbLevel_d = voltSync_q[i];
			end
			// (RULE_10) Reduced bias threshold.
			if (sinkCurrent_d[i] > lsc_pkg::LOW_BIAS_HALF) begin
				lowBias_d = 1'b0;
			end
		end
		// (RULE_22) Sleep when all disabled.
		sleepMode_d = sinkEn_q == 5'h00;
	end

	// Registers the sink outputs.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sinkOn_q      <= 5'h00;
			sinkCurrent_q <= '0;
			fbLevel_q     <= lsc_pkg::FB_IDLE;
			lowBias_q     <= 1'b1;
			sleepMode_q   <= 1'b1;
		end else begin
			sinkOn_q      <= sinkOn_d;
			sinkCurrent_q <= sinkCurrent_d;
			fbLevel_q     <= fbLevel_d;
			lowBias_q     <= lowBias_d;
			sleepMode_q   <= sleepMode_d;
		end
	end

	// Chooses the pump multiplier from the feedback headroom.
	always_comb begin
		mode_d    = mode_q;
		downCnt_d = 16'h0000;
		if (sleepMode_q) begin
			mode_d = lsc_pkg::CP_1X;
		// (RULE_02) Step up on demand.
		end else if (fbLevel_q < lsc_pkg::FB_LOW_THR) begin
			case (mode_q)
				lsc_pkg::CP_1X:  mode_d = lsc_pkg::CP_1P5;
				lsc_pkg::CP_1P5: mode_d = lsc_pkg::CP_2X;
				default:         mode_d = lsc_pkg::CP_2X;
			endcase
		// (RULE_02) Hysteresis on step down.
		end else if (fbLevel_q > lsc_pkg::FB_HIGH_THR && mode_q != lsc_pkg::CP_1X) begin
			downCnt_d = downCnt_q + 16'h0001;
			if (downCnt_q >= 16'(MODE_DOWN_CYC - 1)) begin
				downCnt_d = 16'h0000;
				mode_d    = (mode_q == lsc_pkg::CP_2X) ? lsc_pkg::CP_1P5 : lsc_pkg::CP_1X;
			end
		end
		// (RULE_01) Pump clock only above 1x.
		cpCnt_d = 9'h000;
		cpClk_d = 1'b0;
		if (mode_q != lsc_pkg::CP_1X) begin
			cpCnt_d = cpCnt_q + 9'h001;
			cpClk_d = cpClk_q;
			if (cpCnt_q >= 9'(lsc_pkg::CP_HALF_CYC - 1)) begin
				cpCnt_d = 9'h000;
				cpClk_d = !cpClk_q;
			end
		end
	end

	// Registers the pump state.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q    <= lsc_pkg::CP_1X;
			downCnt_q <= 16'h0000;
			cpCnt_q   <= 9'h000;
			cpClk_q   <= 1'b0;
		end else begin
			mode_q    <= mode_d;
			downCnt_q <= downCnt_d;
			cpCnt_q   <= cpCnt_d;
			cpClk_q   <= cpClk_d;
		end
	end
	assign cpMode_q = mode_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	cp_idle_1x_a: assert property ( // RULE_01
		mode_q == lsc_pkg::CP_1X ##1 mode_q == lsc_pkg::CP_1X |-> !cpClk_q)
		else $error("Pump clock runs in 1x mode.");
	cp_half_period_a: assert property ( // RULE_01
		$rose(cpClk_q) && mode_q != lsc_pkg::CP_1X ##1 mode_q != lsc_pkg::CP_1X [*8]
		|-> cpClk_q)
		else $error("Pump clock half period too short.");
	mode_up_a: assert property ( // RULE_02
		!sleepMode_q && fbLevel_q < lsc_pkg::FB_LOW_THR && mode_q == lsc_pkg::CP_1X
		|=> mode_q == lsc_pkg::CP_1P5)
		else $error("Pump did not step up on low headroom.");
	fb_lowest_a: assert property ( // RULE_03
		sinkOn_q[0] |-> fbLevel_q <= $past(voltSync_q[0]))
		else $error("Feedback is above an active sink.");
	sink_off_a: assert property ( // RULE_07
		!sinkEn_q[1] |=> !sinkOn_q[1] && sinkCurrent_q[1] == 6'h00)
		else $error("Disabled sink still drives current.");
	code_top_a: assert property ( // RULE_06
		sinkOn_d[2] && sinkCode[2] == 5'h1F |=> sinkCurrent_q[2] == 6'h32)
		else $error("Top code is not 25mA.");
	code_mid_a: assert property ( // RULE_05
		sinkOn_d[3] && sinkCode[3] == 5'h0E |=> sinkCurrent_q[3] == 6'h0C)
		else $error("Code 0Eh is not 6mA.");
	code_half_a: assert property ( // RULE_04
		sinkOn_d[4] && sinkCode[4] == 5'h04 |=> sinkCurrent_q[4] == 6'h01)
		else $error("Code 04h is not 0.5mA.");
	open_disable_a: assert property ( // RULE_23
		openSync_q[0] && sinkEn_q[0] && !shutdown |=> !sinkEn_q[0])
		else $error("Open sink stayed enabled.");
	shutdown_clear_a: assert property ( // RULE_21
		shutdown |=> sinkEn_q == 5'h00 && mainLevel_q == 5'h00 && fadeRate_q == 2'h0)
		else $error("Shutdown left a register set.");
	sleep_state_a: assert property ( // RULE_22
		sinkEn_q == 5'h00 |=> sleepMode_q ##1 mode_q == lsc_pkg::CP_1X)
		else $error("Sleep did not stop the pump.");
	side_bank_a: assert property ( // RULE_12
		bank2Sel_q[1] && !bank3Sel_q[1] |-> sinkCode[1] == bank2Level_q)
		else $error("Side bank routed through fade.");

	fade_run_c: cover property (fadeBusy_q && fadeRate_q != 2'h0);
	mode_2x_c: cover property (mode_q == lsc_pkg::CP_2X);
	open_trip_c: cover property (openSync_q[2] && sinkEn_q[2]);
	bias_low_c: cover property (lowBias_q && !sleepMode_q);

endmodule : lsc_led_ctrl

//--- tb/lsc_host_model.sv
`timescale 1ns/1ps
// Host side of the register write port; after its time-zero idle values it drives on falling edges only.
module lsc_host_model #(
	parameter logic [4:0] USED_MASK = 5'h1F
) (
	input  wire logic       clk,
	output logic            regWrEn,
	output logic [4:0]      regAddr,
	output logic [7:0]      regData
);
	// Idle bus at time zero.
	initial begin
		regWrEn = 1'b0;
		regAddr = 5'h00;
		regData = 8'h00;
	end

	// One strobe cycle, after which the idle bus shows the inverted last value.
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk);
		regWrEn = 1'b1;
		regAddr = a;
		regData = (a == lsc_pkg::REG_SINK_EN) ? (d & {3'h0, USED_MASK}) : d;
		@(negedge clk);
		regWrEn = 1'b0;
		regAddr = ~regAddr;
		regData = ~regData;
	endtask : wr

	task automatic fade_in(input logic [1:0] rate, input logic [4:0] en, input logic [4:0] lvl);
		wr(lsc_pkg::REG_FADE_RATE, 8'h00);
		wr(lsc_pkg::REG_MAIN_LEVEL, 8'h04);
		wr(lsc_pkg::REG_FADE_RATE, {6'h00, rate});
		wr(lsc_pkg::REG_SINK_EN, {3'h0, en});
		wr(lsc_pkg::REG_MAIN_LEVEL, {3'h0, lvl});
	endtask : fade_in
endmodule : lsc_host_model

//--- tb/lsc_led_ctrl_test.sv
`timescale 1ns/1ps
module lsc_led_ctrl_test;
	localparam int MAX_CYC = 5000;
	logic            clk;
	logic            rst_n;
	logic            shutdown;
	logic            regWrEn;
	logic [4:0]      regAddr;
	logic [7:0]      regData;
	logic [4:0]      sinkOpen;
	logic [4:0][7:0] sinkVolt;
	logic [4:0][5:0] sinkCurrent;
	logic [4:0]      sinkOn;
	logic [1:0]      cpMode;
	logic            cpClk;
	logic [7:0]      fbLevel;
	logic            lowBias;
	logic            sleepMode;
	logic            fadeBusy;
	int              n_fail;
	int              n_checks;
	int              cycles;
	int              n;
	logic [4:0]      e;

	lsc_led_ctrl #(.FADE_CYC1(8), .FADE_CYC2(12), .FADE_CYC3(16), .MODE_DOWN_CYC(10)) dut (
		.clk(clk), .rst_n(rst_n), .shutdown(shutdown), .regWrEn(regWrEn),
		.regAddr(regAddr), .regData(regData), .sinkOpen(sinkOpen), .sinkVolt(sinkVolt),
		.sinkCurrent_q(sinkCurrent), .sinkOn_q(sinkOn), .cpMode_q(cpMode), .cpClk_q(cpClk),
		.fbLevel_q(fbLevel), .lowBias_q(lowBias), .sleepMode_q(sleepMode),
		.fadeBusy_q(fadeBusy)
	);

	lsc_host_model host (.clk(clk), .regWrEn(regWrEn), .regAddr(regAddr), .regData(regData));

	// Free-running clock, 8 ns period.
	initial clk = 1'b0;
	always #4 clk = ~clk;

	// Expected sink current in half-milliamp units for a code.
	function automatic logic [5:0] half(input logic [4:0] c);
		if (c == 5'h00) return 6'h00;
		if (c <= 5'h03) return 6'h01;
		if (c <= 5'h0D) return {1'b0, c} - 6'h03;
		if (c <= 5'h1D) return 6'h0C + 6'h02 * ({1'b0, c} - 6'h0E);
		return (c == 5'h1E) ? 6'h2E : 6'h32;
	endfunction : half

	// Compares one value and counts it.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc

	// Waits for the next main-bank change and checks it moved by one code.
	task automatic step(input int dir, output int gap);
		logic [5:0] last;
		last = sinkCurrent[0];
		gap = 0;
		while (sinkCurrent[0] === last && gap < 100) begin
			@(negedge clk);
			gap++;
		end
		e = (dir > 0) ? e + 5'h01 : e - 5'h01;
		chk({2'h0, sinkCurrent[0]}, {2'h0, half(e)});
	endtask : step

	// Bounded wait for the ramp to finish.
	task automatic wait_idle();
		n = 0;
		while (fadeBusy !== 1'b0 && n < 300) begin
			@(negedge clk);
			n++;
		end
		cyc(3);
	endtask : wait_idle

	task automatic test_done();
		$display("checks %0d, failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	// Cuts a hang short.
	always @(posedge clk) begin
		cycles++;
		if (cycles == MAX_CYC) begin
			n_fail++;
			test_done();
		end
	end

	// Main sequence.
	initial begin
		rst_n = 1'b0;
		shutdown = 1'b0;
		sinkOpen = 5'h00;
		sinkVolt = {5{8'h80}};
		n_fail = 0;
		n_checks = 0;
		cycles = 0;
		e = 5'h00;
		cyc(4);
		rst_n = 1'b1;
		cyc(1);
		chk({3'h0, sinkOn}, 8'h00);
		chk({7'h0, sleepMode}, 8'h01);
		chk(fbLevel, lsc_pkg::FB_IDLE);
		host.wr(lsc_pkg::REG_SINK_EN, 8'h1F);
		for (int c = 0; c < 32; c++) begin
			host.wr(lsc_pkg::REG_MAIN_LEVEL, 8'(c));
			cyc(3);
			chk({2'h0, sinkCurrent[4]}, {2'h0, half(5'(c))});
			chk({7'h0, sinkOn[4]}, {7'h0, c != 0});
			chk({7'h0, lowBias}, {7'h0, half(5'(c)) <= 6'h08});
		end
		// Banks: sink 1 in bank 2, sink 2 in bank 3.
		host.wr(lsc_pkg::REG_BANK2_SEL, 8'h02);
		host.wr(lsc_pkg::REG_BANK3_SEL, 8'h04);
		host.wr(lsc_pkg::REG_BANK2_LEVEL, 8'h0A);
		host.wr(lsc_pkg::REG_BANK3_LEVEL, 8'h14);
		cyc(3);
		chk({2'h0, sinkCurrent[1]}, 8'h07);
		chk({2'h0, sinkCurrent[2]}, 8'h18);
		chk({2'h0, sinkCurrent[0]}, 8'h32);
		// Ramp up at rate 1, rate change and bank 2 write mid-ramp.
		host.fade_in(2'h1, 5'h1F, 5'h08);
		e = 5'h04;
		step(1, n);
		step(1, n);
		chk(8'(n), 8'h08);
		host.wr(lsc_pkg::REG_FADE_RATE, 8'h03);
		host.wr(lsc_pkg::REG_BANK2_LEVEL, 8'h0C);
		cyc(2);
		chk({2'h0, sinkCurrent[1]}, 8'h09);
		chk({7'h0, fadeBusy}, 8'h01);
		step(1, n);
		step(1, n);
		chk(8'(n), 8'h10);
		wait_idle();
		chk({2'h0, sinkCurrent[0]}, 8'h05);
		// Rate 2, then redirect downward mid-ramp.
		host.wr(lsc_pkg::REG_FADE_RATE, 8'h02);
		host.wr(lsc_pkg::REG_MAIN_LEVEL, 8'h1F);
		step(1, n);
		step(1, n);
		chk(8'(n), 8'h0C);
		host.wr(lsc_pkg::REG_MAIN_LEVEL, 8'h08);
		step(-1, n);
		wait_idle();
		chk({2'h0, sinkCurrent[0]}, 8'h05);
		// Cancel a running ramp; the redirected ramp settled on code 08h.
		e = 5'h08;
		host.wr(lsc_pkg::REG_MAIN_LEVEL, 8'h1F);
		step(1, n);
		host.wr(lsc_pkg::REG_FADE_RATE, 8'h00);
		cyc(3);
		chk({2'h0, sinkCurrent[0]}, 8'h32);
		chk({7'h0, fadeBusy}, 8'h00);
		// Pump: low headroom on one sink raises the mode.
		sinkVolt[2] = 8'h10;
		cyc(5);
		chk(fbLevel, 8'h10);
		cyc(5);
		chk({6'h0, cpMode}, {6'h0, lsc_pkg::CP_2X});
		n = 0;
		while (cpClk !== 1'b1 && n < 600) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (cpClk === 1'b1 && n < 600) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n), 8'(lsc_pkg::CP_HALF_CYC));
		sinkVolt[2] = 8'h40;
		cyc(30);
		chk({6'h0, cpMode}, {6'h0, lsc_pkg::CP_2X});
		sinkVolt[2] = 8'h80;
		cyc(40);
		chk({6'h0, cpMode}, {6'h0, lsc_pkg::CP_1X});
		cyc(3);
		chk({7'h0, cpClk}, 8'h00);
		// Open sink is dropped and stays off.
		sinkOpen = 5'h08;
		cyc(6);
		chk({7'h0, sinkOn[3]}, 8'h00);
		sinkOpen = 5'h00;
		cyc(6);
		chk({3'h0, sinkOn}, 8'h17);
		// Shutdown, unmapped write, defaults.
		shutdown = 1'b1;
		cyc(1);
		shutdown = 1'b0;
		cyc(3);
		chk({3'h0, sinkOn}, 8'h00);
		host.wr(5'h1F, 8'hFF);
		host.wr(lsc_pkg::REG_SINK_EN, 8'h1F);
		cyc(3);
		chk({3'h0, sinkOn}, 8'h00);
		host.wr(lsc_pkg::REG_MAIN_LEVEL, 8'h0A);
		cyc(3);
		chk({2'h0, sinkCurrent[1]}, 8'h07);
		chk({3'h0, sinkOn}, 8'h1F);
		host.wr(lsc_pkg::REG_SINK_EN, 8'h00);
		cyc(4);
		chk({7'h0, sleepMode}, 8'h01);
		chk({6'h0, cpMode}, {6'h0, lsc_pkg::CP_1X});
		chk({7'h0, cpClk}, 8'h00);
		test_done();
	end
endmodule : lsc_led_ctrl_test
